/* File: hdl/dscg_gate_word.sv */
// One gating word: writable implemented bits, reserved bits held at zero
`timescale 1ns/10ps
module dscg_gate_word #(
  parameter logic [31:0] IMPL_MASK = dscg_pkg::GATE_IMPL_MASK
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wr_en_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] value_out
);

  logic [31:0] next_value;

  always_comb begin
    next_value = value_out;
    if (wr_en_in) begin
      next_value = wdata_in & IMPL_MASK; // [R10]
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_out <= dscg_pkg::GATE_RESET; // [R4]
    end else begin
      value_out <= next_value;
    end
  end

endmodule : dscg_gate_word

/* File: hdl/dscg_pkg.sv */
// Constants, types and helpers for the deep-sleep unit clock gating block
package dscg_pkg;

  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;

  // Register offsets
  localparam logic [11:0] RUN_ENABLES_OFS   = 12'h108;
  localparam logic [11:0] SLEEP_ENABLES_OFS = 12'h118;
  localparam logic [11:0] DEEP_ENABLES_OFS  = 12'h128;
  localparam logic [11:0] RUN_CLOCK_CFG_OFS = 12'h060;
  localparam logic [11:0] FAULT_STATUS_OFS  = 12'h200;
  localparam logic [11:0] FAULT_MASK_OFS    = 12'h204;

  // Reset values of the gating, config and fault words; implemented bits of the gating words
  localparam logic [31:0] GATE_RESET     = 32'h0000_0000;
  localparam logic [31:0] GATE_IMPL_MASK = 32'h5000_007f;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam logic [31:0] IRQ_RESET      = 32'h0000_0000;

  // Field positions
  localparam int          PHY_BIT   = 30;
  localparam int          MAC_BIT   = 28;
  localparam int          PORT_LSB  = 0;
  localparam int          PORT_MSB  = 6;
  localparam int          AUTO_GATE_BIT = 27;
  localparam int          UNIT_NUM  = 9;

  // Power mode input codes
  localparam logic [1:0]  PWR_RUN   = 2'h0;
  localparam logic [1:0]  PWR_SLEEP = 2'h1;
  localparam logic [1:0]  PWR_DEEP  = 2'h2;

  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP  = 3'b100
  } dscg_mode_t;

  // One bit per controlled unit, packed in register order
  typedef struct packed {
    logic       eth_phy_clock_gate;
    logic       eth_mac_clock_gate;
    logic [6:0] port_clock_gate;
  } dscg_units_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dscg_req_t;

  function automatic dscg_units_t word_to_units(input logic [31:0] w);
    dscg_units_t u;
    u.eth_phy_clock_gate = w[PHY_BIT];
    u.eth_mac_clock_gate = w[MAC_BIT];
    u.port_clock_gate    = w[PORT_MSB:PORT_LSB];
    return u;
  endfunction : word_to_units

  function automatic logic [31:0] units_to_word(input dscg_units_t u);
    logic [31:0] w;
    w                    = 32'h0000_0000;
    w[PHY_BIT]           = u.eth_phy_clock_gate;
    w[MAC_BIT]           = u.eth_mac_clock_gate;
    w[PORT_MSB:PORT_LSB] = u.port_clock_gate;
    return w;
  endfunction : units_to_word

endpackage : dscg_pkg

/* File: hdl/dscg_top.sv */
// Unit clock gating control with run, sleep and deep-sleep enable words
// Behaviour
// R1: Deep-sleep word at 0x128, read/write, resets zero
// R2: Set bit clocks its unit, clear stops it
// R3: Access to a gated unit raises bus fault
// R4: All gating bits read zero after reset
// R5: Separate run, sleep and deep-sleep words
// R6: Sleep words act only with auto gating
// R7: Bit 30 gates the Ethernet PHY clock
// R8: Bit 28 gates the Ethernet MAC clock
// R9: Bits 6..0 gate ports G down to A
// R10: Reserved bits read zero; software preserves them
// R11: Software enables units needed in deep-sleep
// R12: Deep-sleep word governs clocks only there
`timescale 1ns/10ps
module dscg_top (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire dscg_pkg::dscg_req_t   req_in,
  output logic [31:0]                rd_data_out,
  input  wire logic [1:0]            power_mode_in,
  input  wire dscg_pkg::dscg_units_t unit_access_in,
  output dscg_pkg::dscg_units_t      unit_clk_en_out,
  output logic                       bus_fault_out,
  output logic                       irq_out
);

  localparam int WORDS = 3;
  localparam logic [11:0] WORD_OFS [WORDS] = '{
    dscg_pkg::RUN_ENABLES_OFS,
    dscg_pkg::SLEEP_ENABLES_OFS,
    dscg_pkg::DEEP_ENABLES_OFS
  };

  logic [31:0]           gate_word [WORDS];
  logic [31:0]           run_unit_clock_enables;
  logic [31:0]           sleep_unit_clock_enables;
  logic [31:0]           deep_sleep_unit_clock_enables;
  logic [31:0]           run_clock_config;
  logic                  auto_clock_gating;
  logic [31:0]           fault_status;
  logic [31:0]           fault_mask;
  dscg_pkg::dscg_mode_t  mode;
  dscg_pkg::dscg_units_t fault_units;

  logic [31:0]           next_run_clock_config;
  logic [31:0]           next_fault_status;
  logic [31:0]           next_fault_mask;
  logic [31:0]           next_rd_data;
  dscg_pkg::dscg_mode_t  next_mode;
  dscg_pkg::dscg_units_t next_unit_clk_en;
  logic                  next_bus_fault;

  // Three independent words, one per operating mode
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      dscg_gate_word #(
        .IMPL_MASK (dscg_pkg::GATE_IMPL_MASK)
      ) u_word (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .wr_en_in  (req_in.wr && req_in.addr == WORD_OFS[gi]), // [R5] [R1]
        .wdata_in  (req_in.wdata),
        .value_out (gate_word[gi])
      );
    end
  endgenerate

  assign run_unit_clock_enables        = gate_word[0];
  assign sleep_unit_clock_enables      = gate_word[1];
  assign deep_sleep_unit_clock_enables = gate_word[2];
  assign auto_clock_gating             = run_clock_config[dscg_pkg::AUTO_GATE_BIT];

  // Operating mode tracking; the unused code falls back to run
  always_comb begin
    unique case (power_mode_in)
      dscg_pkg::PWR_SLEEP: next_mode = dscg_pkg::MODE_SLEEP;
      dscg_pkg::PWR_DEEP:  next_mode = dscg_pkg::MODE_DEEP;
      default:             next_mode = dscg_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= dscg_pkg::MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Effective unit enables; registered so the gate cells see glitch-free levels
  always_comb begin
    next_unit_clk_en = dscg_pkg::word_to_units(run_unit_clock_enables); // [R6]
    if (auto_clock_gating) begin
      unique case (mode)
        dscg_pkg::MODE_SLEEP: begin
          next_unit_clk_en = dscg_pkg::word_to_units(sleep_unit_clock_enables); // [R6]
        end
        dscg_pkg::MODE_DEEP: begin
          // Bit 30 PHY, bit 28 MAC, bits 6..0 ports
          next_unit_clk_en = dscg_pkg::word_to_units(deep_sleep_unit_clock_enables); // [R12] [R2] [R7] [R8] [R9]
        end
        dscg_pkg::MODE_RUN: begin
          next_unit_clk_en = dscg_pkg::word_to_units(run_unit_clock_enables);
        end
      endcase
    end
  end

  // Fault on any access to a unit whose clock is stopped
  always_comb begin
    fault_units    = unit_access_in & ~unit_clk_en_out; // [R3]
    next_bus_fault = |fault_units; // [R3]
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unit_clk_en_out <= '0; // [R4]
      bus_fault_out   <= 1'b0;
    end else begin
      unit_clk_en_out <= next_unit_clk_en;
      bus_fault_out   <= next_bus_fault;
    end
  end

  // Configuration, fault status and mask; a new fault wins over its clear
  always_comb begin
    next_run_clock_config = run_clock_config;
    next_fault_mask       = fault_mask;
    next_fault_status     = fault_status;
    if (req_in.wr) begin
      unique case (req_in.addr)
        dscg_pkg::RUN_CLOCK_CFG_OFS: begin
          next_run_clock_config = req_in.wdata;
        end
        dscg_pkg::FAULT_MASK_OFS: begin
          next_fault_mask = req_in.wdata & dscg_pkg::GATE_IMPL_MASK;
        end
        dscg_pkg::FAULT_STATUS_OFS: begin
          next_fault_status = fault_status & ~req_in.wdata;
        end
        default: begin
          next_fault_mask = fault_mask;
        end
      endcase
    end
    next_fault_status = next_fault_status | dscg_pkg::units_to_word(fault_units);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_clock_config <= dscg_pkg::CFG_RESET;
      fault_status     <= dscg_pkg::IRQ_RESET;
      fault_mask       <= dscg_pkg::IRQ_RESET;
    end else begin
      run_clock_config <= next_run_clock_config;
      fault_status     <= next_fault_status;
      fault_mask       <= next_fault_mask;
    end
  end

  assign irq_out = |(fault_status & fault_mask);

  // Read data one cycle after the strobe; unmapped and idle read zero
  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (req_in.rd) begin
      unique case (req_in.addr)
        dscg_pkg::RUN_ENABLES_OFS:   next_rd_data = run_unit_clock_enables;
        dscg_pkg::SLEEP_ENABLES_OFS: next_rd_data = sleep_unit_clock_enables;
        dscg_pkg::DEEP_ENABLES_OFS:  next_rd_data = deep_sleep_unit_clock_enables; // [R1]
        dscg_pkg::RUN_CLOCK_CFG_OFS: next_rd_data = run_clock_config;
        dscg_pkg::FAULT_STATUS_OFS:  next_rd_data = fault_status;
        dscg_pkg::FAULT_MASK_OFS:    next_rd_data = fault_mask;
        default:                     next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= next_rd_data;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  AST_DEEP_WRITE: assert property ( // [R1]
    req_in.wr && req_in.addr == dscg_pkg::DEEP_ENABLES_OFS
    |=> deep_sleep_unit_clock_enables == ($past(req_in.wdata) & dscg_pkg::GATE_IMPL_MASK))
    else $error("Deep-sleep word did not take the write");

  AST_DEEP_READ: assert property ( // [R1]
    req_in.rd && req_in.addr == dscg_pkg::DEEP_ENABLES_OFS
    |=> rd_data_out == $past(deep_sleep_unit_clock_enables))
    else $error("Deep-sleep word read back wrong");

  AST_RESERVED_ZERO: assert property ( // [R10]
    (deep_sleep_unit_clock_enables & ~dscg_pkg::GATE_IMPL_MASK) == 32'h0000_0000)
    else $error("Reserved gating bit set");

  AST_RESET_ZERO: assert property ( // [R4]
    $rose(rst_n_in) |-> deep_sleep_unit_clock_enables == 32'h0000_0000
    && unit_clk_en_out == '0)
    else $error("Gating not cleared by reset");

  AST_SEPARATE: assert property ( // [R5]
    req_in.wr && req_in.addr != dscg_pkg::DEEP_ENABLES_OFS
    |=> $stable(deep_sleep_unit_clock_enables))
    else $error("Deep-sleep word changed by another write");

  AST_DEEP_APPLIED: assert property ( // [R12]
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating
    |=> unit_clk_en_out == dscg_pkg::word_to_units($past(deep_sleep_unit_clock_enables)))
    else $error("Deep-sleep enables not applied");

  AST_NO_ACG: assert property ( // [R6]
    !auto_clock_gating
    |=> unit_clk_en_out == dscg_pkg::word_to_units($past(run_unit_clock_enables)))
    else $error("Sleep words acted without auto gating");

  AST_PHY_BIT: assert property ( // [R7]
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating
    ##1 $past(deep_sleep_unit_clock_enables[dscg_pkg::PHY_BIT])
    |-> unit_clk_en_out.eth_phy_clock_gate)
    else $error("PHY enable not on bit 30");

  AST_MAC_BIT: assert property ( // [R8]
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating
    && !deep_sleep_unit_clock_enables[dscg_pkg::MAC_BIT]
    |=> !unit_clk_en_out.eth_mac_clock_gate)
    else $error("MAC enable not on bit 28");

  AST_PORT_BITS: assert property ( // [R9]
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating
    |=> unit_clk_en_out.port_clock_gate
        == $past(deep_sleep_unit_clock_enables[dscg_pkg::PORT_MSB:dscg_pkg::PORT_LSB]))
    else $error("Port enables not on bits 6..0");

  AST_FAULT: assert property ( // [R3] [R2]
    |(unit_access_in & ~unit_clk_en_out)
    |=> bus_fault_out && fault_status != 32'h0000_0000)
    else $error("Access to gated unit gave no fault");

  AST_NO_FAULT: assert property ( // [R3]
    (unit_access_in & ~unit_clk_en_out) == '0 |=> !bus_fault_out)
    else $error("Fault without gated access");

  AST_RUN_APPLIED: assert property ( // [R12] [R5]
    mode == dscg_pkg::MODE_RUN
    |=> unit_clk_en_out == dscg_pkg::word_to_units($past(run_unit_clock_enables)))
    else $error("Run enables not applied in run mode");

  AST_SLEEP_APPLIED: assert property ( // [R6] [R12]
    mode == dscg_pkg::MODE_SLEEP && auto_clock_gating
    |=> unit_clk_en_out == dscg_pkg::word_to_units($past(sleep_unit_clock_enables)))
    else $error("Sleep enables not applied in sleep mode");

  AST_MODE_TRACK: assert property ( // [R12]
    power_mode_in == dscg_pkg::PWR_DEEP |=> mode == dscg_pkg::MODE_DEEP)
    else $error("Deep-sleep mode not taken");

  AST_PHY_OFF: assert property ( // [R7]
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating
    && !deep_sleep_unit_clock_enables[dscg_pkg::PHY_BIT]
    |=> !unit_clk_en_out.eth_phy_clock_gate)
    else $error("PHY clocked with its bit clear");

  AST_MAC_ON: assert property ( // [R8]
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating
    && deep_sleep_unit_clock_enables[dscg_pkg::MAC_BIT]
    |=> unit_clk_en_out.eth_mac_clock_gate)
    else $error("MAC not clocked with its bit set");

  // Run and sleep words share the deep-sleep layout, so the same bits stay dead
  AST_OTHER_WORDS_CLEAN: assert property ( // [R10]
    ((run_unit_clock_enables | sleep_unit_clock_enables) & ~dscg_pkg::GATE_IMPL_MASK)
    == 32'h0000_0000)
    else $error("Reserved bit set in run or sleep word");

  AST_RD_IDLE: assert property ( // [R1]
    !req_in.rd |=> rd_data_out == 32'h0000_0000)
    else $error("Read data outside the read cycle");

  AST_FAULT_SET: assert property ( // [R3]
    |fault_units
    |=> (fault_status & dscg_pkg::units_to_word($past(fault_units)))
        == dscg_pkg::units_to_word($past(fault_units)))
    else $error("Fault status bit not set");

  AST_FAULT_STICKY: assert property ( // [R3]
    !(req_in.wr && req_in.addr == dscg_pkg::FAULT_STATUS_OFS)
    |=> (fault_status & $past(fault_status)) == $past(fault_status))
    else $error("Fault status bit lost without a clear");

  AST_FAULT_CLEAR: assert property ( // [R3]
    req_in.wr && req_in.addr == dscg_pkg::FAULT_STATUS_OFS && fault_units == '0
    |=> (fault_status & $past(req_in.wdata)) == 32'h0000_0000)
    else $error("Fault status bit not cleared by a one");

  COV_DEEP_SET: cover property (
    req_in.wr && req_in.addr == dscg_pkg::DEEP_ENABLES_OFS && req_in.wdata != 32'h0000_0000);
  COV_DEEP_ACTIVE: cover property (
    mode == dscg_pkg::MODE_DEEP && auto_clock_gating ##1 unit_clk_en_out != '0);
  COV_FAULT_IRQ: cover property (bus_fault_out ##1 irq_out);
  COV_SLEEP_ACTIVE: cover property (
    mode == dscg_pkg::MODE_SLEEP && auto_clock_gating ##1 unit_clk_en_out != '0);
  COV_STATUS_CLEAR: cover property (
    req_in.wr && req_in.addr == dscg_pkg::FAULT_STATUS_OFS && fault_status != 32'h0000_0000);

endmodule : dscg_top

/* File: tb/dscg_top_test.sv */
// Self-checking bench for the deep-sleep unit clock gating block
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module dscg_top_test;
  logic                  mclk_in;
  logic                  rst_n_in;
  dscg_pkg::dscg_req_t   req_in;
  logic [31:0]           rd_data_out;
  logic [1:0]            power_mode_in;
  dscg_pkg::dscg_units_t unit_access_in;
  dscg_pkg::dscg_units_t unit_clk_en_out;
  logic                  bus_fault_out;
  logic                  irq_out;
  int                    n_errors = 0;
  int                    checks_done = 0;
  int                    seed = 61;
  logic [31:0]           rd_q[$];
  logic                  flt_q[$];
  logic                  rd_pend;
  logic [31:0]           exp_rd;
  logic                  exp_f;
  logic [31:0]           wd [3];
  logic [31:0]           w;
  logic [31:0]           st;
  logic [31:0]           sel;
  logic [8:0]            en9;
  logic [11:0]           ofs [6] = '{dscg_pkg::RUN_ENABLES_OFS, dscg_pkg::SLEEP_ENABLES_OFS,
                                     dscg_pkg::DEEP_ENABLES_OFS, dscg_pkg::RUN_CLOCK_CFG_OFS,
                                     dscg_pkg::FAULT_STATUS_OFS, dscg_pkg::FAULT_MASK_OFS};

  dscg_top u_dscg_top (
    .mclk_in         (mclk_in),
    .rst_n_in        (rst_n_in),
    .req_in          (req_in),
    .rd_data_out     (rd_data_out),
    .power_mode_in   (power_mode_in),
    .unit_access_in  (unit_access_in),
    .unit_clk_en_out (unit_clk_en_out),
    .bus_fault_out   (bus_fault_out),
    .irq_out         (irq_out)
  );

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic final_report();
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic bus(input logic wr, input logic rd, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    req_in <= '{wr: wr, rd: rd, addr: a, wdata: d};
  endtask : bus

  // Note goes in before the strobe so the watcher always finds it waiting
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 12'h000, 32'h0000_0000);
  endtask : idle

  function automatic logic [8:0] units(input logic [31:0] v);
    return {v[30], v[28], v[6:0]};
  endfunction : units

  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge mclk_in) rd_pend <= req_in.rd;

  always @(negedge mclk_in) begin
    if (rd_pend === 1'b1) begin
      exp_rd = rd_q.pop_front();
      `CHK("rd_data_out", rd_data_out, exp_rd)
    end
    if (bus_fault_out === 1'b1) begin
      exp_f = (flt_q.size() > 0) ? flt_q.pop_front() : 1'b0;
      `CHK("bus_fault_out", bus_fault_out, exp_f)
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    final_report();
  end

  initial begin
    rst_n_in       = 1'b0;
    req_in         = '0;
    power_mode_in  = 2'h0;
    unit_access_in = '0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
    idle(1);
    @(negedge mclk_in);
    `CHK("unit_clk_en_out", unit_clk_en_out, 9'h000)
    // Back-to-back write and read, reserved bits must drop out
    repeat (4) begin
      w = $random(seed);
      bus(1'b1, 1'b0, dscg_pkg::DEEP_ENABLES_OFS, w);
      rd(dscg_pkg::DEEP_ENABLES_OFS, w & dscg_pkg::GATE_IMPL_MASK);
    end
    bus(1'b1, 1'b0, dscg_pkg::DEEP_ENABLES_OFS, 32'hffff_ffff);
    rd(dscg_pkg::DEEP_ENABLES_OFS, 32'h5000_007f);
    bus(1'b1, 1'b0, 12'h12c, 32'hffff_ffff);
    rd(12'h12c, 32'h0000_0000);
    // Distinct words per mode; port A kept gated in deep-sleep for the fault pass
    for (int k = 0; k < 3; k++) begin
      wd[k] = $random(seed) & dscg_pkg::GATE_IMPL_MASK;
      if (k == 2) wd[k] = (wd[k] & 32'hffff_fffe) | 32'h4000_0000;
      bus(1'b1, 1'b0, ofs[k], wd[k]);
    end
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, 1'b0, dscg_pkg::RUN_CLOCK_CFG_OFS, a ? 32'h0800_0000 : 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin
        if (m != 0) @(posedge mclk_in);
        power_mode_in <= 2'(m);
        idle(3);
        sel = (a == 0 || m == 0 || m == 3) ? wd[0] : wd[m];
        @(negedge mclk_in);
        `CHK("unit_clk_en_out", unit_clk_en_out, units(sel))
      end
    end
    // Every unit touched once, back to back, in deep-sleep
    bus(1'b1, 1'b0, dscg_pkg::FAULT_MASK_OFS, 32'hffff_ffff);
    power_mode_in <= dscg_pkg::PWR_DEEP;
    idle(3);
    en9 = units(wd[2]);
    st  = 32'h0000_0000;
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk_in);
      unit_access_in <= dscg_pkg::dscg_units_t'(9'h001 << i);
      if (!en9[i]) begin
        flt_q.push_back(1'b1);
        st = st | ((i < 7) ? (32'h1 << i) : (i == 7 ? 32'h1000_0000 : 32'h4000_0000));
      end
    end
    @(posedge mclk_in);
    unit_access_in <= '0;
    idle(2);
    rd(dscg_pkg::FAULT_STATUS_OFS, st);
    idle(1);
    @(negedge mclk_in);
    `CHK("irq_out", irq_out, 1'b1)
    bus(1'b1, 1'b0, dscg_pkg::FAULT_MASK_OFS, 32'h0000_0000);
    idle(2);
    @(negedge mclk_in);
    `CHK("irq_out", irq_out, 1'b0)
    bus(1'b1, 1'b0, dscg_pkg::FAULT_STATUS_OFS, st);
    rd(dscg_pkg::FAULT_STATUS_OFS, 32'h0000_0000);
    bus(1'b1, 1'b0, dscg_pkg::FAULT_MASK_OFS, 32'hffff_ffff);
    idle(2);
    @(negedge mclk_in);
    `CHK("irq_out", irq_out, 1'b0)
    `CHK("fault_notes", 32'(flt_q.size()), 32'h0000_0000)
    final_report();
  end
endmodule : dscg_top_test
